/* File: hw/omc_consts.svh */
// constants of the operating-mode controller
`ifndef OMC_CONSTS_SVH
`define OMC_CONSTS_SVH
// first fetch address after reset, no vector fetch
`define OMC_RESET_PC 14'h3FFD
// opcode expected at the reset address
`define OMC_JUMP_OPCODE 8'hBC
// clock period in ns (40 MHz)
`define OMC_CLK_PERIOD_NS 32'h19
// time the host keeps the mode-select pin low after reset release, in ns
`define OMC_MS_HOLD_NS 32'h4B
// least hold time rounded up to whole cycles
`define OMC_MS_HOLD_CYC ((`OMC_MS_HOLD_NS + `OMC_CLK_PERIOD_NS - 32'h1) / `OMC_CLK_PERIOD_NS)
// synchroniser depth on the mode-select pin
`define OMC_SYNC_STAGES 2'h2
// answer data for commands that carry none
`define OMC_NO_DATA 8'h00
`endif

/* File: hw/omc_pkg.sv */
// types and command acceptance table of the operating-mode controller
`default_nettype none
package omc_pkg;
  typedef enum logic [2:0] {
    OMC_INIT = 3'h0,
    OMC_RUN = 3'h1,
    OMC_HALT = 3'h2,
    OMC_TRACE = 3'h3,
    OMC_WAIT = 3'h4,
    OMC_STOP = 3'h5
  } omc_mode_t;

  typedef enum logic [2:0] {
    OMC_CMD_MEM = 3'h0,
    OMC_CMD_MEM_STAT = 3'h1,
    OMC_CMD_HALT = 3'h2,
    OMC_CMD_REG = 3'h3,
    OMC_CMD_TRACE = 3'h4,
    OMC_CMD_RESUME = 3'h5,
    OMC_CMD_FORCE_RST = 3'h6,
    OMC_CMD_NOP = 3'h7
  } omc_cmd_t;

  typedef enum logic [1:0] {
    OMC_ST_OK = 2'h0,
    OMC_ST_REFUSED = 2'h1,
    OMC_ST_WAIT_ERR = 2'h2,
    OMC_ST_RSVD = 2'h3
  } omc_status_t;

  typedef enum logic [1:0] {
    OMC_OP_PLAIN = 2'h0,
    OMC_OP_WAIT = 2'h1,
    OMC_OP_STOP = 2'h2,
    OMC_OP_BREAK = 2'h3
  } omc_op_t;

  typedef enum logic [1:0] {
    OMC_H_IDLE = 2'h0,
    OMC_H_SEND = 2'h1,
    OMC_H_RESP = 2'h2
  } omc_host_state_t;

  // which command is served in which mode; both ends use the same table
  function automatic omc_status_t omc_verdict(omc_mode_t m, omc_cmd_t c);
    omc_status_t s;
    logic low_power;
    logic active;
    s = OMC_ST_REFUSED;
    low_power = (m == OMC_WAIT) || (m == OMC_STOP);
    active = (m == OMC_RUN) || (m == OMC_HALT) || (m == OMC_TRACE);
    case (c)
      OMC_CMD_HALT: begin
        if (m != OMC_INIT) s = OMC_ST_OK;
      end
      OMC_CMD_MEM, OMC_CMD_FORCE_RST: begin
        if (active) s = OMC_ST_OK;
      end
      OMC_CMD_MEM_STAT: begin
        if (low_power) s = OMC_ST_WAIT_ERR;
        else if (active) s = OMC_ST_OK;
      end
      OMC_CMD_REG, OMC_CMD_TRACE, OMC_CMD_RESUME: begin
        if (m == OMC_HALT) s = OMC_ST_OK;
      end
      default: s = OMC_ST_REFUSED;
    endcase
    return s;
  endfunction : omc_verdict
endpackage : omc_pkg
`default_nettype wire

/* File: hw/omc_link_if.sv */
// debug link between the debug host and the mode controller
`default_nettype none
interface omc_link_if;
  // open-drain mode-select pin, pulled up
  logic host_pin_out;
  logic host_pin_oe;
  logic pin_level;
  // command channel
  logic cmd_valid;
  omc_pkg::omc_cmd_t cmd_code;
  logic [15:0] cmd_addr;
  logic cmd_write;
  logic [7:0] cmd_wdata;
  logic cmd_ready;
  // answer channel and mode report
  logic resp_valid;
  omc_pkg::omc_status_t resp_status;
  logic [7:0] resp_data;
  omc_pkg::omc_mode_t dev_mode;

  // pullup wins unless the host pulls low
  assign pin_level = !(host_pin_oe && !host_pin_out);

  modport dev (
    input pin_level, cmd_valid, cmd_code, cmd_addr, cmd_write, cmd_wdata,
    output cmd_ready, resp_valid, resp_status, resp_data, dev_mode
  );
  modport host (
    input cmd_ready, resp_valid, resp_status, resp_data, dev_mode,
    output host_pin_out, host_pin_oe, cmd_valid, cmd_code, cmd_addr, cmd_write, cmd_wdata
  );
endinterface : omc_link_if
`default_nettype wire

/* File: hw/omc_device.sv */
// operating-mode controller: device end of the debug link
`include "omc_consts.svh"
`default_nettype none
// Notes on behaviour
// R1 - mode pin high at reset: run
// R2 - run starts at address 3FFD
// R3 - no vector fetch; first opcode expected jump
// R4 - pin low or forced reset: debug halt
// R5 - halt command enters debug halt
// R6 - software break instruction enters debug halt
// R7 - breakpoint match enters debug halt
// R8 - halted cpu executes no user code
// R9 - memory and halt commands accepted run/halt
// R10 - register, trace, resume only when halted
// R11 - wait instruction stops cpu clock
// R12 - program counter frozen during wait
// R13 - interrupt ends wait, pc plus one
// R14 - wake from wait uses no vector
// R15 - in wait only halt, status access
// R16 - status access in wait: error, no access
// R17 - halt command wakes wait into halt
// R18 - wait keeps clocks, regulation, pin states
// R19 - stop without enable forces illegal reset
// R20 - mode pin caught once per reset
module omc_device #(
  parameter int PC_W = 14
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // debug link
  omc_link_if.dev link,
  // cpu core
  input wire logic cpu_op_done,
  input wire omc_pkg::omc_op_t cpu_op_kind,
  input wire logic [PC_W-1:0] cpu_next_pc,
  input wire logic [7:0] cpu_opcode,
  input wire logic bkpt_match,
  input wire logic irq_req,
  input wire logic stop_enable_option,
  output logic [PC_W-1:0] cpu_pc,
  output logic cpu_run,
  output logic cpu_clk_en,
  output logic sys_clk_en,
  output logic regulator_full,
  output logic illegal_op_reset,
  output logic jump_missing,
  output logic run_mode_selected,
  // memory and cpu register access
  output logic mem_req,
  output logic mem_space,
  output logic mem_we,
  output logic [15:0] mem_addr,
  output logic [7:0] mem_wdata,
  input wire logic [7:0] mem_rdata
);

  // the reset address must fit the program counter
  if (PC_W < 14) begin : g_bad_pc_w
    $error("omc_device: PC_W below 14 cannot hold the reset address");
  end

  logic ms_meta;
  logic ms_sync;
  omc_pkg::omc_mode_t mode;
  logic [1:0] init_cnt;
  logic take;
  omc_pkg::omc_cmd_t cmd;
  omc_pkg::omc_status_t verdict;
  logic take_ok;
  logic cmd_halts;
  logic is_mem_cmd;
  logic executing;
  logic stop_trap;
  logic first_fetch;
  logic s1_valid;
  logic s1_mem;
  omc_pkg::omc_status_t s1_status;

  // command decode against the current mode
  assign take = link.cmd_valid && link.cmd_ready;
  assign cmd = link.cmd_code;
  assign verdict = omc_pkg::omc_verdict(mode, cmd); // [R9] [R10] [R15]
  assign take_ok = take && (verdict == omc_pkg::OMC_ST_OK);
  assign cmd_halts = take_ok && ((cmd == omc_pkg::OMC_CMD_HALT) || (cmd == omc_pkg::OMC_CMD_FORCE_RST));
  assign is_mem_cmd = (cmd == omc_pkg::OMC_CMD_MEM) || (cmd == omc_pkg::OMC_CMD_MEM_STAT) ||
                      (cmd == omc_pkg::OMC_CMD_REG);
  assign executing = (mode == omc_pkg::OMC_RUN) || (mode == omc_pkg::OMC_TRACE);
  assign stop_trap = !cmd_halts && (mode == omc_pkg::OMC_RUN) && cpu_op_done &&
                     (cpu_op_kind == omc_pkg::OMC_OP_STOP) && !stop_enable_option; // [R19]

  // mode pin synchroniser; idles high like the pullup
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      ms_meta <= 1'b1;
      ms_sync <= 1'b1;
    end else begin
      ms_meta <= link.pin_level;
      ms_sync <= ms_meta;
    end
  end

  // settle count so the sampled level is the one seen after release
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      init_cnt <= 2'h0;
    end else if (mode != omc_pkg::OMC_INIT) begin
      init_cnt <= 2'h0;
    end else if (init_cnt != `OMC_SYNC_STAGES) begin
      init_cnt <= init_cnt + 2'h1;
    end
  end

  // selected mode, held until the next reset
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      run_mode_selected <= 1'b0;
    end else if (mode == omc_pkg::OMC_INIT && init_cnt == `OMC_SYNC_STAGES) begin
      run_mode_selected <= ms_sync; // [R20]
    end
  end

  // operating mode; debug commands outrank cpu events in the same cycle
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      mode <= omc_pkg::OMC_INIT;
    end else if (mode == omc_pkg::OMC_INIT) begin
      if (init_cnt == `OMC_SYNC_STAGES) begin
        mode <= ms_sync ? omc_pkg::OMC_RUN : omc_pkg::OMC_HALT; // [R1] [R4] [R20]
      end
    end else if (cmd_halts) begin
      mode <= omc_pkg::OMC_HALT; // [R4] [R5] [R17]
    end else begin
      case (mode)
        omc_pkg::OMC_RUN: begin
          if (bkpt_match || (cpu_op_done && cpu_op_kind == omc_pkg::OMC_OP_BREAK)) begin
            mode <= omc_pkg::OMC_HALT; // [R6] [R7]
          end else if (cpu_op_done && cpu_op_kind == omc_pkg::OMC_OP_WAIT) begin
            mode <= omc_pkg::OMC_WAIT; // [R11]
          end else if (cpu_op_done && cpu_op_kind == omc_pkg::OMC_OP_STOP) begin
            // an illegal stop resets the core and samples the pin again
            mode <= stop_enable_option ? omc_pkg::OMC_STOP : omc_pkg::OMC_INIT; // [R19]
          end
        end
        omc_pkg::OMC_HALT: begin
          if (take_ok && cmd == omc_pkg::OMC_CMD_RESUME) begin
            mode <= omc_pkg::OMC_RUN; // [R10]
          end else if (take_ok && cmd == omc_pkg::OMC_CMD_TRACE) begin
            mode <= omc_pkg::OMC_TRACE; // [R10]
          end
        end
        omc_pkg::OMC_TRACE: begin
          if (cpu_op_done || bkpt_match) begin
            mode <= omc_pkg::OMC_HALT; // [R8]
          end
        end
        omc_pkg::OMC_WAIT, omc_pkg::OMC_STOP: begin
          if (irq_req) begin
            mode <= omc_pkg::OMC_RUN; // [R13] [R14]
          end
        end
        default: begin
          mode <= omc_pkg::OMC_INIT;
        end
      endcase
    end
  end

  // program counter; wake adds one and never loads a vector
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      cpu_pc <= PC_W'(`OMC_RESET_PC);
    end else if (mode == omc_pkg::OMC_INIT || (take_ok && cmd == omc_pkg::OMC_CMD_FORCE_RST)) begin
      cpu_pc <= PC_W'(`OMC_RESET_PC); // [R2] [R3]
    end else if (cmd_halts) begin
      cpu_pc <= cpu_pc; // [R17]
    end else if (executing && cpu_op_done && cpu_op_kind != omc_pkg::OMC_OP_WAIT &&
                 cpu_op_kind != omc_pkg::OMC_OP_STOP) begin
      cpu_pc <= cpu_next_pc;
    end else if ((mode == omc_pkg::OMC_WAIT || mode == omc_pkg::OMC_STOP) && irq_req) begin
      cpu_pc <= cpu_pc + PC_W'(1); // [R12] [R13] [R14]
    end
  end

  // first instruction from the reset address should be the jump
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      first_fetch <= 1'b1;
      jump_missing <= 1'b0;
    end else if (mode == omc_pkg::OMC_INIT || (take_ok && cmd == omc_pkg::OMC_CMD_FORCE_RST)) begin
      first_fetch <= 1'b1;
    end else if (first_fetch && executing && cpu_op_done) begin
      first_fetch <= 1'b0;
      jump_missing <= (cpu_opcode != `OMC_JUMP_OPCODE); // [R3]
    end
  end

  // cpu and clock controls, one cycle behind the mode; cpu_run falls together with the mode on a halting command
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      cpu_run <= 1'b0;
      cpu_clk_en <= 1'b0;
      sys_clk_en <= 1'b1;
      regulator_full <= 1'b1;
      illegal_op_reset <= 1'b0;
    end else begin
      cpu_run <= executing && !cmd_halts; // [R8]
      cpu_clk_en <= (mode != omc_pkg::OMC_WAIT) && (mode != omc_pkg::OMC_STOP); // [R11]
      // wait keeps system clocks and full regulation; pin holding is outside
      sys_clk_en <= (mode != omc_pkg::OMC_STOP); // [R18]
      regulator_full <= (mode != omc_pkg::OMC_STOP); // [R18]
      illegal_op_reset <= stop_trap; // [R19]
    end
  end

  // command pipeline: take, access, answer; one command in flight
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      link.cmd_ready <= 1'b0;
      link.dev_mode <= omc_pkg::OMC_INIT;
      s1_valid <= 1'b0;
      s1_mem <= 1'b0;
      s1_status <= omc_pkg::OMC_ST_REFUSED;
    end else begin
      link.cmd_ready <= !take && (mode != omc_pkg::OMC_INIT);
      link.dev_mode <= mode;
      s1_valid <= take;
      if (take) begin
        s1_status <= verdict; // [R16]
        s1_mem <= (verdict == omc_pkg::OMC_ST_OK) && is_mem_cmd;
      end
    end
  end

  // memory side strobe; refused and wait-time status commands never access
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      mem_req <= 1'b0;
      mem_space <= 1'b0;
      mem_we <= 1'b0;
      mem_addr <= 16'h0000;
      mem_wdata <= 8'h00;
    end else begin
      mem_req <= take_ok && is_mem_cmd; // [R9] [R16]
      if (take) begin
        mem_space <= (cmd == omc_pkg::OMC_CMD_REG);
        mem_we <= link.cmd_write;
        mem_addr <= link.cmd_addr;
        mem_wdata <= link.cmd_wdata;
      end
    end
  end

  // answer two cycles after the take
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      link.resp_valid <= 1'b0;
      link.resp_status <= omc_pkg::OMC_ST_OK;
      link.resp_data <= `OMC_NO_DATA;
    end else begin
      link.resp_valid <= s1_valid;
      if (s1_valid) begin
        link.resp_status <= s1_status;
        link.resp_data <= s1_mem ? mem_rdata : `OMC_NO_DATA;
      end
    end
  end

endmodule : omc_device
`default_nettype wire

/* File: hw/omc_host.sv */
// debug host end: drives mode select at reset and issues debug commands
`include "omc_consts.svh"
`default_nettype none
module omc_host #(
  parameter bit DEBUG_ON_RESET = 1'b1,
  parameter int HOLD_CYC = `OMC_MS_HOLD_CYC
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // debug link
  omc_link_if.host link,
  // user command port
  input wire logic user_start,
  input wire omc_pkg::omc_cmd_t user_cmd,
  input wire logic [15:0] user_addr,
  input wire logic user_write,
  input wire logic [7:0] user_wdata,
  output logic user_ready,
  output logic user_done,
  output logic user_refused,
  output omc_pkg::omc_status_t user_status,
  output logic [7:0] user_rdata,
  // device mode seen on the link
  output logic dev_halted,
  output logic dev_waiting
);

  // hold count must be at least one cycle and fit its counter
  if (HOLD_CYC < 1 || HOLD_CYC > 15) begin : g_bad_hold
    $error("omc_host: HOLD_CYC must lie in 1..15");
  end

  logic [3:0] hold_cnt;
  omc_pkg::omc_host_state_t state;
  logic user_take;

  assign user_take = user_start && user_ready && (state == omc_pkg::OMC_H_IDLE);
  // open drain: the pin is only ever pulled low
  assign link.host_pin_out = 1'b0;

  // keep mode select low through reset and a few cycles past release
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      hold_cnt <= 4'h0;
      link.host_pin_oe <= DEBUG_ON_RESET; // [R4]
    end else if (hold_cnt != 4'(HOLD_CYC)) begin
      hold_cnt <= hold_cnt + 4'h1;
    end else begin
      link.host_pin_oe <= 1'b0;
    end
  end

  // device mode as reported on the link
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      dev_halted <= 1'b0;
      dev_waiting <= 1'b0;
    end else begin
      dev_halted <= (link.dev_mode == omc_pkg::OMC_HALT);
      dev_waiting <= (link.dev_mode == omc_pkg::OMC_WAIT) || (link.dev_mode == omc_pkg::OMC_STOP);
    end
  end

  // command sequencer; commands the device would refuse are held back here
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      state <= omc_pkg::OMC_H_IDLE;
      user_ready <= 1'b1;
      user_done <= 1'b0;
      user_refused <= 1'b0;
      user_status <= omc_pkg::OMC_ST_OK;
      user_rdata <= 8'h00;
      link.cmd_valid <= 1'b0;
      link.cmd_code <= omc_pkg::OMC_CMD_NOP;
      link.cmd_addr <= 16'h0000;
      link.cmd_write <= 1'b0;
      link.cmd_wdata <= 8'h00;
    end else begin
      user_done <= 1'b0;
      user_refused <= 1'b0;
      case (state)
        omc_pkg::OMC_H_IDLE: begin
          if (user_take) begin
            // mode report may lag; the device still has the final say
            if (omc_pkg::omc_verdict(link.dev_mode, user_cmd) == omc_pkg::OMC_ST_REFUSED) begin
              user_refused <= 1'b1; // [R10] [R15]
            end else begin
              link.cmd_valid <= 1'b1; // [R9]
              link.cmd_code <= user_cmd;
              link.cmd_addr <= user_addr;
              link.cmd_write <= user_write;
              link.cmd_wdata <= user_wdata;
              user_ready <= 1'b0;
              state <= omc_pkg::OMC_H_SEND;
            end
          end
        end
        omc_pkg::OMC_H_SEND: begin
          if (link.cmd_ready) begin
            link.cmd_valid <= 1'b0;
            state <= omc_pkg::OMC_H_RESP;
          end
        end
        omc_pkg::OMC_H_RESP: begin
          if (link.resp_valid) begin
            user_done <= 1'b1;
            user_status <= link.resp_status;
            user_rdata <= link.resp_data;
            user_ready <= 1'b1;
            state <= omc_pkg::OMC_H_IDLE;
          end
        end
        default: begin
          state <= omc_pkg::OMC_H_IDLE;
        end
      endcase
    end
  end

endmodule : omc_host
`default_nettype wire

/* File: verification/omc_link_assertions.sv */
// concurrent checks on the debug link between host and device ends
`default_nettype none
module omc_link_assertions (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // link signals
  input wire logic cmd_valid,
  input wire logic cmd_ready,
  input wire omc_pkg::omc_cmd_t cmd_code,
  input wire logic resp_valid,
  input wire omc_pkg::omc_status_t resp_status,
  input wire logic [7:0] resp_data,
  input wire omc_pkg::omc_mode_t dev_mode
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!reset_n);

  // dev_mode one cycle after a take shows the mode the verdict used
  logic take;
  assign take = cmd_valid && cmd_ready;

  AST_ANSWER_TWO: assert property (
    take |=> !cmd_ready && !resp_valid ##1 resp_valid) else $error("answer not two cycles after take");
  AST_RESP_PULSE: assert property (
    resp_valid |=> !resp_valid) else $error("answer longer than one cycle");
  AST_MEM_RUN_OK: assert property (
    take && cmd_code == omc_pkg::OMC_CMD_MEM ##1 dev_mode == omc_pkg::OMC_RUN |=> resp_status == omc_pkg::OMC_ST_OK)
    else $error("memory access refused in run");
  AST_WAIT_STATUS: assert property (
    take && cmd_code == omc_pkg::OMC_CMD_MEM_STAT ##1 dev_mode == omc_pkg::OMC_WAIT
    |=> resp_status == omc_pkg::OMC_ST_WAIT_ERR && resp_data == 8'h00) else $error("status access in wait not error");
  AST_HALT_ENTRY: assert property (
    take && cmd_code == omc_pkg::OMC_CMD_HALT ##1 dev_mode != omc_pkg::OMC_INIT |=> dev_mode == omc_pkg::OMC_HALT)
    else $error("halt command did not halt");
  AST_WAKE_HALT: assert property (
    take && cmd_code == omc_pkg::OMC_CMD_HALT ##1 dev_mode == omc_pkg::OMC_WAIT
    |=> (dev_mode == omc_pkg::OMC_HALT) [*2]) else $error("halt in wait did not stay halted");
  AST_RESUME_RUN: assert property (
    take && cmd_code == omc_pkg::OMC_CMD_RESUME ##1 dev_mode == omc_pkg::OMC_HALT |=> dev_mode == omc_pkg::OMC_RUN)
    else $error("resume did not run");
  AST_TRACE_STEP: assert property (
    take && cmd_code == omc_pkg::OMC_CMD_TRACE ##1 dev_mode == omc_pkg::OMC_HALT |=> dev_mode == omc_pkg::OMC_TRACE)
    else $error("trace did not step");
  AST_FORCE_HALT: assert property (
    take && cmd_code == omc_pkg::OMC_CMD_FORCE_RST ##1 dev_mode inside {omc_pkg::OMC_RUN, omc_pkg::OMC_HALT}
    |=> dev_mode == omc_pkg::OMC_HALT) else $error("forced reset did not halt");
endmodule : omc_link_assertions
`default_nettype wire

/* File: verification/testbench.sv */
// self-checking bench: host and device ends joined by the debug link
`default_nettype none
`define CHK(nm, exp, got) begin cmp_count++; if ((got) !== (exp)) begin failures++; \
  $display("wrong value %s expected %0h seen %0h", nm, exp, got); end end
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic cpu_op_done = 1'b0;
  logic bkpt_match = 1'b0;
  logic irq_req = 1'b0;
  logic stop_enable_option = 1'b0;
  logic user_start = 1'b0;
  logic user_write = 1'b0;
  omc_pkg::omc_op_t cpu_op_kind = omc_pkg::OMC_OP_PLAIN;
  omc_pkg::omc_cmd_t user_cmd = omc_pkg::OMC_CMD_NOP;
  logic [13:0] cpu_next_pc = 14'h0000;
  logic [7:0] cpu_opcode = 8'h00;
  logic [7:0] mem_rdata = 8'h5A;
  logic [7:0] user_wdata = 8'h00;
  logic [15:0] user_addr = 16'h0000;
  logic [13:0] cpu_pc;
  logic [7:0] user_rdata;
  logic cpu_run, cpu_clk_en, sys_clk_en, regulator_full, illegal_op_reset, jump_missing, run_mode_selected;
  logic user_ready, user_done, user_refused, dev_halted, dev_waiting, got_ref, seen;
  logic mem_req, mem_space, mem_we;
  logic [15:0] mem_addr;
  logic [7:0] mem_wdata;
  omc_pkg::omc_status_t user_status;
  int failures = 0;
  int cmp_count = 0;
  int mem_hits = 0;

  // clock and the two ends
  always #12.5 ref_clk = ~ref_clk;
  // memory strobes counted mid-cycle, where the pulse is settled
  always @(negedge ref_clk) if (mem_req === 1'b1) mem_hits++;
  omc_link_if link ();
  omc_device omc_device_inst (.ref_clk(ref_clk), .reset_n(reset_n), .link(link.dev), .cpu_op_done(cpu_op_done),
    .cpu_op_kind(cpu_op_kind), .cpu_next_pc(cpu_next_pc), .cpu_opcode(cpu_opcode), .bkpt_match(bkpt_match),
    .irq_req(irq_req), .stop_enable_option(stop_enable_option), .cpu_pc(cpu_pc), .cpu_run(cpu_run),
    .cpu_clk_en(cpu_clk_en), .sys_clk_en(sys_clk_en), .regulator_full(regulator_full),
    .illegal_op_reset(illegal_op_reset), .jump_missing(jump_missing), .run_mode_selected(run_mode_selected),
    .mem_req(mem_req), .mem_space(mem_space), .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .mem_rdata(mem_rdata));
  omc_host omc_host_inst (.ref_clk(ref_clk), .reset_n(reset_n), .link(link.host), .user_start(user_start),
    .user_cmd(user_cmd), .user_addr(user_addr), .user_write(user_write), .user_wdata(user_wdata),
    .user_ready(user_ready), .user_done(user_done), .user_refused(user_refused), .user_status(user_status),
    .user_rdata(user_rdata), .dev_halted(dev_halted), .dev_waiting(dev_waiting));
  omc_link_assertions omc_link_assertions_inst (.ref_clk(ref_clk), .reset_n(reset_n), .cmd_valid(link.cmd_valid),
    .cmd_ready(link.cmd_ready), .cmd_code(link.cmd_code), .resp_valid(link.resp_valid),
    .resp_status(link.resp_status), .resp_data(link.resp_data), .dev_mode(link.dev_mode));

  // one user command; extra settle cycles since host mode flags lag by two
  task automatic cmd(input omc_pkg::omc_cmd_t c);
    int n;
    n = 0;
    while (user_ready !== 1'b1 && n < 20) begin
      @(negedge ref_clk);
      n++;
    end
    @(posedge ref_clk);
    user_cmd <= c;
    user_start <= 1'b1;
    @(posedge ref_clk);
    user_start <= 1'b0;
    got_ref = 1'b0;
    seen = 1'b0;
    n = 0;
    while (!seen && n < 20) begin
      @(negedge ref_clk);
      n++;
      got_ref = (user_refused === 1'b1);
      seen = (user_done === 1'b1) || got_ref;
    end
    `CHK("answer", 1'b1, seen)
    repeat (3) @(negedge ref_clk);
  endtask : cmd

  // one finished cpu instruction; catches the illegal reset pulse
  task automatic op(input omc_pkg::omc_op_t k, input logic [13:0] pc, input logic [7:0] opc);
    @(posedge ref_clk);
    cpu_op_done <= 1'b1;
    cpu_op_kind <= k;
    cpu_next_pc <= pc;
    cpu_opcode <= opc;
    @(posedge ref_clk);
    cpu_op_done <= 1'b0;
    seen = 1'b0;
    repeat (4) begin
      @(negedge ref_clk);
      if (illegal_op_reset === 1'b1) seen = 1'b1;
    end
  endtask : op

  // one-cycle pulse on interrupt or breakpoint
  task automatic kick(input bit irq);
    @(posedge ref_clk);
    if (irq) irq_req <= 1'b1;
    else bkpt_match <= 1'b1;
    @(posedge ref_clk);
    irq_req <= 1'b0;
    bkpt_match <= 1'b0;
    repeat (3) @(negedge ref_clk);
  endtask : kick

  task automatic t_start;
    op(omc_pkg::OMC_OP_PLAIN, 14'h0123, 8'hBC);
    `CHK("halted", 1'b1, dev_halted)
    `CHK("reset pc", 14'h3FFD, cpu_pc)
    `CHK("cpu run", 1'b0, cpu_run)
    `CHK("run sel", 1'b0, run_mode_selected)
    $display("test start done");
  endtask : t_start

  task automatic t_run;
    int hits;
    cmd(omc_pkg::OMC_CMD_REG);
    `CHK("reg halted", omc_pkg::OMC_ST_OK, user_status)
    `CHK("reg space", 1'b1, mem_space)
    cmd(omc_pkg::OMC_CMD_RESUME);
    `CHK("resumed", 1'b1, cpu_run)
    op(omc_pkg::OMC_OP_PLAIN, 14'h0100, 8'hBC);
    `CHK("jump pc", 14'h0100, cpu_pc)
    `CHK("jump flag", 1'b0, jump_missing)
    @(posedge ref_clk);
    user_addr <= 16'h3FFE;
    user_write <= 1'b1;
    user_wdata <= 8'hA5;
    hits = mem_hits;
    cmd(omc_pkg::OMC_CMD_MEM);
    `CHK("mem data", 8'h5A, user_rdata)
    `CHK("mem req", hits + 1, mem_hits)
    `CHK("mem addr", 16'h3FFE, mem_addr)
    `CHK("mem write", 1'b1, mem_we & !mem_space)
    `CHK("mem wdata", 8'hA5, mem_wdata)
    cmd(omc_pkg::OMC_CMD_REG);
    `CHK("reg in run", 1'b1, got_ref)
    $display("test run done");
  endtask : t_run

  task automatic t_wait;
    int hits;
    op(omc_pkg::OMC_OP_WAIT, 14'h0000, 8'h00);
    `CHK("wait pc", 14'h0100, cpu_pc)
    `CHK("cpu clk", 1'b0, cpu_clk_en)
    `CHK("waiting", 1'b1, dev_waiting)
    `CHK("sys clk", 1'b1, sys_clk_en & regulator_full)
    hits = mem_hits;
    cmd(omc_pkg::OMC_CMD_MEM_STAT);
    `CHK("wait status", omc_pkg::OMC_ST_WAIT_ERR, user_status)
    `CHK("wait no access", hits, mem_hits)
    `CHK("wait data", 8'h00, user_rdata)
    cmd(omc_pkg::OMC_CMD_MEM);
    `CHK("mem in wait", 1'b1, got_ref)
    kick(1'b1);
    `CHK("wake pc", 14'h0101, cpu_pc)
    `CHK("wake clk", 1'b1, cpu_clk_en)
    op(omc_pkg::OMC_OP_WAIT, 14'h0000, 8'h00);
    cmd(omc_pkg::OMC_CMD_HALT);
    `CHK("wait to halt", 1'b1, dev_halted)
    `CHK("halt pc", 14'h0101, cpu_pc)
    $display("test wait done");
  endtask : t_wait

  task automatic t_break;
    cmd(omc_pkg::OMC_CMD_RESUME);
    op(omc_pkg::OMC_OP_BREAK, 14'h0200, 8'h00);
    `CHK("break", 1'b1, dev_halted)
    cmd(omc_pkg::OMC_CMD_RESUME);
    kick(1'b0);
    `CHK("bkpt", 1'b1, dev_halted)
    cmd(omc_pkg::OMC_CMD_RESUME);
    cmd(omc_pkg::OMC_CMD_HALT);
    `CHK("halt cmd", 1'b1, dev_halted)
    cmd(omc_pkg::OMC_CMD_FORCE_RST);
    `CHK("force pc", 14'h3FFD, cpu_pc)
    `CHK("force halt", 1'b1, dev_halted)
    cmd(omc_pkg::OMC_CMD_TRACE);
    `CHK("trace run", 1'b1, cpu_run)
    op(omc_pkg::OMC_OP_PLAIN, 14'h0280, 8'h00);
    `CHK("trace halt", 1'b1, dev_halted)
    `CHK("trace pc", 14'h0280, cpu_pc)
    cmd(omc_pkg::OMC_CMD_RESUME);
    op(omc_pkg::OMC_OP_PLAIN, 14'h0300, 8'h00);
    `CHK("no jump", 1'b1, jump_missing)
    $display("test break done");
  endtask : t_break

  // legal stop first, then stop with the option clear re-enters init; the pin is released by now
  task automatic t_stop;
    @(posedge ref_clk);
    stop_enable_option <= 1'b1;
    op(omc_pkg::OMC_OP_STOP, 14'h0000, 8'h00);
    `CHK("no trap", 1'b0, seen)
    `CHK("stop clk", 1'b0, sys_clk_en | cpu_clk_en)
    kick(1'b1);
    `CHK("stop wake pc", 14'h0301, cpu_pc)
    @(posedge ref_clk);
    stop_enable_option <= 1'b0;
    op(omc_pkg::OMC_OP_STOP, 14'h0000, 8'h00);
    `CHK("illegal", 1'b1, seen)
    repeat (8) @(negedge ref_clk);
    `CHK("mode run", omc_pkg::OMC_RUN, link.dev_mode)
    `CHK("run sel", 1'b1, run_mode_selected)
    `CHK("stop pc", 14'h3FFD, cpu_pc)
    $display("test stop done");
  endtask : t_stop

  task automatic final_report;
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : final_report

  initial begin
    repeat (6) @(posedge ref_clk);
    reset_n <= 1'b1;
    repeat (8) @(negedge ref_clk);
    t_start;
    t_run;
    t_wait;
    t_break;
    t_stop;
    final_report;
  end

  // whole run needs well under a thousand cycles
  initial begin
    repeat (3000) @(posedge ref_clk);
    failures++;
    $display("watchdog expired");
    final_report;
  end
endmodule : testbench
`default_nettype wire
